// *** logic/warn_status_defs.svh ***
`ifndef WARN_STATUS_DEFS_SVH
`define WARN_STATUS_DEFS_SVH

// Register byte addresses (word pairs 0x26:27, 0x28:29, 0x2A:2B)
`define ADDR_WARN       8'h26
`define ADDR_TEMP       8'h28
`define ADDR_FIELD      8'h2A

// Identifier nibbles in bits 15:12
`define ID_WARN         4'hB
`define ID_TEMP         4'hF
`define ID_FIELD        4'hE

// Warning bit positions
`define BIT_IER         11
`define BIT_CRC         10
`define BIT_RSVD        9
`define BIT_SRW         8
`define BIT_XEE         7
`define BIT_TR          6
`define BIT_ESE         5
`define BIT_SAT         4
`define BIT_TCW         3
`define BIT_BSY         2
`define BIT_MSH         1
`define BIT_TOV         0
`define WARN_FLAGS      12

// Reset values
`define WARN_RST        12'h000
`define TEMP_RST        12'h000
`define FIELD_RST       12'h000

// Serial packet framing
`define PKT_BITS        6'h10
`define PKT_BITS_CRC    6'h14
`define CRC_SEED        4'hF
`define CRC_POLY        4'h3

// Temperature limits in eighths relative to 25 C: -60 C and 180 C
`define TEMP_MIN_C      -60
`define TEMP_MAX_C      180
`define TEMP_OFS_C      25
`define TEMP_MIN_Q      16'hFD58
`define TEMP_MAX_Q      16'h04D8

// Zero-crossing step limit: 135 deg of 4096 counts per turn
`define TCW_DEG         135
`define TCW_LIMIT       12'h600
`define ANGLE_HALF      12'h800

// Field refresh timing
`define CLK_MHZ         40
`define FIELD_PERIOD_US 128
`define FIELD_REFRESH_CYCLES (`FIELD_PERIOD_US * `CLK_MHZ)

`endif

// *** logic/warn_status_pkg.sv ***
package warn_status_pkg;

  typedef logic [15:0] reg_word_t;
  typedef logic [11:0] field_t;

  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_WARN  = 2'b01,
    SEL_TEMP  = 2'b10,
    SEL_FIELD = 2'b11
  } reg_sel_e;

endpackage

// *** logic/refresh_tick.sv ***
`timescale 1ns/1ps

module refresh_tick #(
  parameter int unsigned PERIOD = 5120
) (
  input  wire logic clock,  // System clock
  input  wire logic rst_b,  // Async reset, active low
  output logic      tick    // One-cycle pulse each period
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 16'h0001;
    if (cnt_r == 16'(PERIOD - 1)) begin
      cnt_nxt  = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

// *** logic/angle_sensor_warning_status_regs.sv ***
// Notes on behaviour
// - Warning flags latch and hold until the host clears them.
// - Top nibble reads 1011 warning, 1111 temperature, 1110 field.
// - Bad bit count, bit 15 set or code error sets bit 11, drops packet.
// - With CRC check enabled, a CRC mismatch sets bit 10 and drops packet.
// - Bit 8 sets while slew limiting is enabled and engaged.
// - Bit 7 sets when an extended-write command fails.
// - Bit 6 sets outside -60..180 C; temperature clamps at those limits.
// - Bit 5 sets on corrected single-bit memory error during load.
// - Bit 4 sets when any signal-chain signal saturates.
// - Bit 3 sets when successive zero-crossing samples differ over 135 deg.
// - Bit 2 sets when an extended access starts while one is busy.
// - Bit 1 sets when field exceeds the stored high threshold.
// - Bit 0 sets on turns overflow; only turns-count reset clears it.
// - Temperature low 12 bits: signed eighths of a degree from 25 C.
// - Bit 9 reads zero; all three registers are read-only.
// - Summary warning bit asserts on any unmasked warning flag.
// - Error indicator is one on any unmasked error or warning.
`timescale 1ns/1ps
`include "warn_status_defs.svh"

module angle_sensor_warning_status_regs #(
  parameter int unsigned REFRESH_CYCLES = `FIELD_REFRESH_CYCLES
) (
  input  wire logic        clock,                  // 40 MHz clock
  input  wire logic        rst_b,                  // Async reset, active low
  // Register read port
  input  wire logic        rd_en,                  // Read strobe
  input  wire logic [7:0]  rd_addr,                // Register byte address
  output logic [15:0]      rd_data,                // Read data
  output logic             rd_valid,               // Read data valid pulse
  output logic             rd_hit,                 // Address maps a register
  input  wire logic        wr_en,                  // Write strobe, only drives rd_hit
  // Clear commands
  input  wire logic        warn_clear,             // Clear ended warnings except bit 0
  input  wire logic        turns_reset_cmd,        // Turns-count reset
  // Incoming serial packet
  input  wire logic        pkt_valid,              // Packet end pulse
  input  wire logic [5:0]  pkt_bits,               // Bits received
  input  wire logic [15:0] pkt_word,               // Received data
  input  wire logic [3:0]  pkt_crc,                // Received CRC
  input  wire logic        code_error,             // Single-wire code error
  input  wire logic        crc_check_enable,       // Stored CRC check enable
  output logic             pkt_accept,             // Packet passed on
  output logic [15:0]      pkt_word_out,           // Accepted data
  output logic             pkt_drop,               // Packet discarded
  // Conditions
  input  wire logic        slew_limit_enable,      // Slew limiting enabled
  input  wire logic        slew_limit_engaged,     // Limiting applied now
  input  wire logic        ext_cmd_fail,           // Extended command failed
  input  wire logic [15:0] temp_raw,               // Eighths from 25 C
  input  wire logic        temp_valid,             // New temperature
  input  wire logic        mem_loading,            // Memory load in progress
  input  wire logic        mem_single_err,         // Corrected bit error
  input  wire logic        saturation_any,         // Any signal saturated
  input  wire logic        zcd_valid,              // Zero-crossing sample
  input  wire logic [11:0] zcd_angle,              // Zero-crossing angle
  input  wire logic        turns_update,           // Turns count updated
  input  wire logic        ext_start,              // Extended access start
  input  wire logic        ext_busy,               // Extended access busy
  input  wire logic [11:0] field_raw,              // Measured field, gauss
  input  wire logic [11:0] field_high_threshold,   // Strong-field threshold
  input  wire logic        turns_overflow,         // Turns counter wrapped
  // Summaries
  input  wire logic [15:0] warn_mask,              // Per-bit warning mask
  input  wire logic        warn_summary_mask,      // Summary bit mask
  input  wire logic        err_unmasked_any,       // Unmasked error present
  output logic             warning_summary_bit,    // Unmasked warning set
  output logic             error_indicator,        // Any unmasked fault
  output logic             slew_hold               // Encoder at slew rate
);

  localparam logic [11:0] LIMIT = `TCW_LIMIT;
  // Clamp limits in eighths from 25 C; only the low 12 bits are stored
  localparam logic [15:0] TEMP_MIN = `TEMP_MIN_Q;
  localparam logic [15:0] TEMP_MAX = `TEMP_MAX_Q;

  function automatic warn_status_pkg::reg_sel_e decode(input logic [7:0] a);
    unique case ({a[7:1], 1'b0})
      `ADDR_WARN:  decode = warn_status_pkg::SEL_WARN;
      `ADDR_TEMP:  decode = warn_status_pkg::SEL_TEMP;
      `ADDR_FIELD: decode = warn_status_pkg::SEL_FIELD;
      default:     decode = warn_status_pkg::SEL_NONE;
    endcase
  endfunction

  // The CRC nibble lengthens the frame when checking is on
  function automatic logic [5:0] frame_bits(input logic crc_on);
    frame_bits = crc_on ? `PKT_BITS_CRC : `PKT_BITS;
  endfunction

  // Shortest way round the circle, so a wrap through zero is no jump
  function automatic logic [11:0] circ_step(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] d;
    d = a - b;
    circ_step = (d > `ANGLE_HALF) ? (12'h000 - d) : d;
  endfunction

  // Bitwise CRC over the 16 data bits
  function automatic logic [3:0] crc4(input logic [15:0] d);
    logic [3:0] c;
    logic       fb;
    c = `CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c  = {c[2:0], 1'b0} ^ (fb ? `CRC_POLY : 4'h0);
    end
    crc4 = c;
  endfunction

  // Packet checking
  logic        bad_frame;
  logic        bad_crc;
  logic        accept_nxt;
  logic        accept_r;
  logic        drop_nxt;
  logic        drop_r;
  logic [15:0] pword_nxt;
  logic [15:0] pword_r;

  always_comb begin
    bad_frame = pkt_valid & (pkt_word[15] | code_error |
                (pkt_bits != frame_bits(crc_check_enable)));
    bad_crc = pkt_valid & ~bad_frame & crc_check_enable &
              (crc4(pkt_word) != pkt_crc);
    accept_nxt = pkt_valid & ~bad_frame & ~bad_crc;
    drop_nxt   = bad_frame | bad_crc;
    pword_nxt  = accept_nxt ? pkt_word : pword_r;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      accept_r <= 1'b0;
      drop_r   <= 1'b0;
      pword_r  <= 16'h0000;
    end else begin
      accept_r <= accept_nxt;
      drop_r   <= drop_nxt;
      pword_r  <= pword_nxt;
    end
  end

  assign pkt_accept   = accept_r;
  assign pkt_drop     = drop_r;
  assign pkt_word_out = pword_r;

  // Temperature clamping
  logic        temp_low;
  logic        temp_high;
  logic [11:0] temp_nxt;
  logic [11:0] temp_r;

  always_comb begin
    temp_low  = $signed(temp_raw) < $signed(TEMP_MIN);
    temp_high = $signed(temp_raw) > $signed(TEMP_MAX);
    temp_nxt  = temp_r;
    if (temp_valid) begin
      if (temp_low) begin
        temp_nxt = TEMP_MIN[11:0];
      end else if (temp_high) begin
        temp_nxt = TEMP_MAX[11:0];
      end else begin
        temp_nxt = temp_raw[11:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      temp_r <= `TEMP_RST;
    end else begin
      temp_r <= temp_nxt;
    end
  end

  // Field refresh
  logic        field_tick;
  logic        field_strong;
  logic [11:0] field_nxt;
  logic [11:0] field_r;

  // Free-running; the first capture lands one period plus one cycle after reset
  refresh_tick #(
    .PERIOD (REFRESH_CYCLES)
  ) u_refresh (
    .clock (clock),
    .rst_b (rst_b),
    .tick  (field_tick)
  );

  always_comb begin
    field_nxt    = field_tick ? field_raw : field_r;
    field_strong = field_tick & (field_raw > field_high_threshold);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      field_r <= `FIELD_RST;
    end else begin
      field_r <= field_nxt;
    end
  end

  // Zero-crossing step tracking; pair restarts at each turns update
  logic [11:0] zprev_r;
  logic [11:0] zprev_nxt;
  logic        zhave_r;
  logic        zhave_nxt;
  logic [11:0] zstep;
  logic        zbig;

  always_comb begin
    zstep     = circ_step(zcd_angle, zprev_r);
    zbig      = zcd_valid & zhave_r & (zstep > LIMIT);
    zprev_nxt = zcd_valid ? zcd_angle : zprev_r;
    zhave_nxt = zhave_r;
    if (zcd_valid) begin
      zhave_nxt = 1'b1;
    end
    if (turns_update) begin
      zhave_nxt = zcd_valid;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      zprev_r <= 12'h000;
      zhave_r <= 1'b0;
    end else begin
      zprev_r <= zprev_nxt;
      zhave_r <= zhave_nxt;
    end
  end

  // Warning conditions
  logic [`WARN_FLAGS-1:0] cond;
  logic [`WARN_FLAGS-1:0] warn_r;
  logic [`WARN_FLAGS-1:0] warn_nxt;
  logic [`WARN_FLAGS-1:0] clr_vec;

  always_comb begin
    cond = '0;
    cond[`BIT_IER] = bad_frame;
    cond[`BIT_CRC] = bad_crc;
    cond[`BIT_SRW] = slew_limit_enable & slew_limit_engaged;
    cond[`BIT_XEE] = ext_cmd_fail;
    cond[`BIT_TR]  = temp_valid & (temp_low | temp_high);
    cond[`BIT_ESE] = mem_loading & mem_single_err;
    cond[`BIT_SAT] = saturation_any;
    cond[`BIT_TCW] = zbig;
    cond[`BIT_BSY] = ext_start & ext_busy;
    cond[`BIT_MSH] = field_strong;
    cond[`BIT_TOV] = turns_overflow;
  end

  // Per-flag clear; the ordinary clear never reaches bit 0
  always_comb begin
    clr_vec = {`WARN_FLAGS{warn_clear}};
    clr_vec[`BIT_TOV] = turns_reset_cmd;
  end

  // Condition dominates a clear in the same cycle
  for (genvar i = 0; i < `WARN_FLAGS; i++) begin : g_flag
    if (i == `BIT_RSVD) begin : g_rsvd
      assign warn_nxt[i] = 1'b0;
    end else begin : g_std
      assign warn_nxt[i] = cond[i] | (warn_r[i] & ~clr_vec[i]);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      warn_r <= `WARN_RST;
    end else begin
      warn_r <= warn_nxt;
    end
  end

  assign slew_hold = cond[`BIT_SRW];

  // Summaries
  logic warn_any;

  always_comb begin
    warn_any = |(warn_r & ~warn_mask[`WARN_FLAGS-1:0]);
    warning_summary_bit = warn_any & ~warn_summary_mask;
  end

  assign error_indicator = err_unmasked_any | warning_summary_bit;

  // Register readout; writes have no effect
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;
  logic        rvalid_r;

  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      unique case (decode(rd_addr))
        warn_status_pkg::SEL_WARN:  rdata_nxt = {`ID_WARN, warn_r};
        warn_status_pkg::SEL_TEMP:  rdata_nxt = {`ID_TEMP, temp_r};
        warn_status_pkg::SEL_FIELD: rdata_nxt = {`ID_FIELD, field_r};
        warn_status_pkg::SEL_NONE:  rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rd_en;
    end
  end

  assign rd_data  = rdata_r;
  assign rd_valid = rvalid_r;
  assign rd_hit   = (rd_en | wr_en) & (decode(rd_addr) != warn_status_pkg::SEL_NONE);

endmodule

// *** testbench/warn_status_monitor.sv ***
`timescale 1ns/1ps
module warn_status_monitor (
  input wire logic        clock,              // Clock
  input wire logic        rst_b,              // Reset
  input wire logic        rd_en,              // Read
  input wire logic [7:0]  rd_addr,            // Address
  input wire logic [15:0] rd_data,            // Data
  input wire logic        rd_valid,           // Valid
  input wire logic        pkt_valid,          // Packet
  input wire logic [5:0]  pkt_bits,           // Count
  input wire logic [15:0] pkt_word,           // Word
  input wire logic        code_error,         // Code
  input wire logic        crc_check_enable,   // CRC on
  input wire logic        pkt_accept,         // Taken
  input wire logic        pkt_drop,           // Dropped
  input wire logic        slew_limit_enable,  // Slew
  input wire logic        slew_limit_engaged, // Engaged
  input wire logic        slew_hold,          // Hold
  input wire logic        warn_clear,         // Clear
  input wire logic        turns_reset_cmd,    // Turns
  input wire logic [15:0] warn_mask,          // Mask
  input wire logic        warn_summary_mask,  // Mask
  input wire logic        warning_summary_bit,// Summary
  input wire logic        err_unmasked_any,   // Error
  input wire logic        error_indicator     // Indicator
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_held;
    warning_summary_bit && !warn_clear && !turns_reset_cmd;
  endsequence
  sequence s_masks_still;
    $stable(warn_mask) && $stable(warn_summary_mask);
  endsequence
  property p_sticky;
    s_held ##1 s_masks_still |-> warning_summary_bit;
  endproperty
  a_sticky: assert property (p_sticky) else $error("warning dropped");
  property p_id_warn;
    rd_en && rd_addr[7:1] == 7'h13 |=> rd_data[15:12] == 4'hB && !rd_data[9];
  endproperty
  a_id_warn: assert property (p_id_warn) else $error("warning id");
  property p_id_temp;
    rd_en && rd_addr[7:1] == 7'h14 |=> rd_data[15:12] == 4'hF;
  endproperty
  a_id_temp: assert property (p_id_temp) else $error("temperature id");
  property p_id_field;
    rd_en && rd_addr[7:1] == 7'h15 |=> rd_data[15:12] == 4'hE;
  endproperty
  a_id_field: assert property (p_id_field) else $error("field id");
  property p_rd_lat;
    rd_valid == $past(rd_en);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read timing");
  property p_hdr_drop;
    pkt_valid && (pkt_word[15] || code_error) |=> pkt_drop && !pkt_accept;
  endproperty
  a_hdr_drop: assert property (p_hdr_drop) else $error("bad packet kept");
  property p_crc_off;
    pkt_valid && !crc_check_enable && !pkt_word[15] && !code_error
      && pkt_bits == 6'h10 |=> pkt_accept && !pkt_drop;
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("good packet lost");
  property p_slew;
    slew_hold == (slew_limit_enable && slew_limit_engaged);
  endproperty
  a_slew: assert property (p_slew) else $error("slew hold");
  property p_sum_mask;
    warn_summary_mask |-> !warning_summary_bit;
  endproperty
  a_sum_mask: assert property (p_sum_mask) else $error("summary mask");
  property p_err_ind;
    error_indicator == (err_unmasked_any || warning_summary_bit);
  endproperty
  a_err_ind: assert property (p_err_ind) else $error("error indicator");
endmodule

bind angle_sensor_warning_status_regs warn_status_monitor mon (.*);

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input  wire logic        clock,      // Clock
  input  wire logic [15:0] rd_data,    // Answer
  input  wire logic        rd_hit,     // Mapped
  output logic             rd_en,      // Read
  output logic             wr_en,      // Write
  output logic [7:0]       rd_addr,    // Address
  output logic             pkt_valid,  // Packet end
  output logic [5:0]       pkt_bits,   // Count
  output logic [15:0]      pkt_word,   // Word
  output logic [3:0]       pkt_crc,    // CRC
  output logic             code_error  // Code fault
);
  initial begin
    {rd_en, wr_en, pkt_valid, code_error} = 4'h0;
    {rd_addr, pkt_bits, pkt_word, pkt_crc} = 34'h0;
  end
  // Released address and data lines show the inverse, not a stale value; strobes drop to zero
  task automatic access(input logic w, input logic [7:0] a,
                        output logic [15:0] d, output logic h);
    @(posedge clock);
    #2 {rd_en, wr_en, rd_addr} = {!w, w, a};
    #1 h = rd_hit;
    @(posedge clock);
    #2 d = rd_data;
    {rd_en, wr_en, rd_addr} = {2'b00, ~a};
  endtask
  task automatic send(input logic [5:0] n, input logic [15:0] w,
                      input logic [3:0] c, input logic e);
    @(posedge clock);
    #2 {pkt_valid, pkt_bits, pkt_word, pkt_crc, code_error} = {1'b1, n, w, c, e};
    @(posedge clock);
    #2 {pkt_valid, pkt_bits, pkt_word, pkt_crc, code_error} = {1'b0, ~n, ~w, ~c, 1'b0};
  endtask
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clock = 0, rst_b = 0, rd_en, wr_en, rd_valid, rd_hit, pkt_valid, code_error;
  logic [7:0] rd_addr;
  logic [5:0] pkt_bits;
  logic [3:0] pkt_crc;
  logic [15:0] rd_data, pkt_word, pkt_word_out, d, s = 16'h0048, temp_raw = 0, warn_mask = 0;
  logic [11:0] zcd_angle = 0, field_raw = 0, field_high_threshold = 12'h4B0;
  logic h, pkt_accept, pkt_drop, warning_summary_bit, error_indicator, slew_hold;
  logic warn_clear = 0, turns_reset_cmd = 0, crc_check_enable = 0, temp_valid = 0;
  logic slew_limit_enable = 0, slew_limit_engaged = 0, ext_cmd_fail = 0, mem_loading = 0;
  logic mem_single_err = 0, saturation_any = 0, zcd_valid = 0, turns_update = 0;
  logic ext_start = 0, ext_busy = 0, turns_overflow = 0, warn_summary_mask = 0;
  logic err_unmasked_any = 0;
  int n_fail = 0, n_checks = 0, cb[6] = '{8, 7, 5, 4, 2, 0};
  always #12.5 clock = ~clock;
  angle_sensor_warning_status_regs #(.REFRESH_CYCLES(8)) dut (.*);
  host_model host (.*);
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [3:0] crc4(input logic [15:0] w);
    logic [3:0] c;
    c = 4'hF;
    for (int i = 15; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ w[i]) ? 4'h3 : 4'h0);
    return c;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdw(input logic [7:0] a, input logic [15:0] e);
    host.access(1'b0, a, d, h);
    chk(d, e);
    chk({15'h0, h}, 16'h0001);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic clr(input logic t);
    cyc(1);
    {warn_clear, turns_reset_cmd} = {!t, t};
    cyc(1);
    {warn_clear, turns_reset_cmd} = 2'b00;
  endtask
  task automatic pk(input logic [5:0] n, input logic [15:0] w, input logic [3:0] c,
                    input logic e, input int f);
    host.send(n, w, c, e);
    chk({14'h0, pkt_accept, pkt_drop}, f < 0 ? 16'h2 : 16'h1);
    if (f < 0) chk(pkt_word_out, w);
    rdw(8'h26, f < 0 ? 16'hB000 : 16'hB000 | (16'h1 << f));
    clr(0);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    stop_test;
  end
  initial begin
    cyc(20);
    rst_b = 1;
    rdw(8'h27, 16'hB000); rdw(8'h28, 16'hF000); rdw(8'h2A, 16'hE000);
    host.access(1'b0, 8'h40, d, h);
    chk(d, 16'h0000);
    chk({15'h0, h}, 16'h0000);
    host.access(1'b1, 8'h26, d, h);
    chk({15'h0, h}, 16'h0001);
    rdw(8'h26, 16'hB000);
    $display("test registers done");
    foreach (cb[i]) begin
      cyc(1);
      case (cb[i])
        8: {slew_limit_enable, slew_limit_engaged} = 2'b11;
        7: {ext_cmd_fail, slew_limit_engaged} = 2'b11;
        5: {mem_loading, mem_single_err} = 2'b11;
        4: saturation_any = 1;
        // host breaks the wait on purpose
        2: {ext_start, ext_busy} = 2'b11;
        default: turns_overflow = 1;
      endcase
      cyc(1);
      chk({15'h0, slew_hold}, cb[i] == 8 ? 16'h0001 : 16'h0000);
      {slew_limit_enable, slew_limit_engaged, ext_cmd_fail, mem_loading} = 4'h0;
      {mem_single_err, saturation_any, ext_start, ext_busy, turns_overflow} = 5'h0;
      cyc(3);
      rdw(8'h26, 16'hB000 | (16'h1 << cb[i]));
      clr(0);
      rdw(8'h26, cb[i] == 0 ? 16'hB001 : 16'hB000);
    end
    clr(1);
    mem_single_err = 1;
    cyc(1);
    mem_single_err = 0;
    rdw(8'h26, 16'hB000);
    $display("test flags done");
    foreach (cb[i]) begin
      s = nx(s);
      temp_raw = i == 0 ? 16'hFD57 : i == 1 ? 16'hFD58 : i == 2 ? 16'h04D8 :
                 i == 3 ? 16'h04D9 : {7'h0, s[8:0]};
      temp_valid = 1;
      cyc(1);
      temp_valid = 0;
      rdw(8'h28, {4'hF, i == 0 ? 12'hD58 : i == 3 ? 12'h4D8 : temp_raw[11:0]});
      rdw(8'h26, i == 0 || i == 3 ? 16'hB040 : 16'hB000);
      clr(0);
    end
    for (int i = 0; i < 4; i++) begin
      s = nx(s);
      pk(6'h10, s & 16'h7FFF, s[3:0], 0, -1);
    end
    pk(6'h10, s | 16'h8000, 4'h0, 0, 11);
    pk(6'h0F, s & 16'h7FFF, 4'h0, 0, 11);
    pk(6'h10, s & 16'h7FFF, 4'h0, 1, 11);
    crc_check_enable = 1;
    pk(6'h14, s & 16'h7FFF, crc4(s & 16'h7FFF), 0, -1);
    pk(6'h14, s & 16'h7FFF, ~crc4(s & 16'h7FFF), 0, 10);
    pk(6'h10, s & 16'h7FFF, crc4(s & 16'h7FFF), 0, 11);
    $display("test packets done");
    turns_overflow = 1;
    cyc(1);
    turns_overflow = 0;
    rdw(8'h26, 16'hB001);
    rst_b = 0;
    cyc(2);
    rst_b = 1;
    chk(pkt_word_out, 16'h0000);
    rdw(8'h26, 16'hB000);
    foreach (cb[i]) begin
      cyc(1);
      {zcd_valid, zcd_angle} = {1'b1, i < 3 ? 12'h600 * i[11:0] : 12'h201};
      cyc(1);
      zcd_valid = 0;
    end
    rdw(8'h26, 16'hB008);
    clr(0);
    turns_update = 1;
    cyc(1);
    {turns_update, zcd_valid, zcd_angle} = {2'b01, 12'hA01};
    cyc(1);
    zcd_valid = 0;
    rdw(8'h26, 16'hB000);
    field_raw = 12'h4B0;
    cyc(10);
    rdw(8'h2B, 16'hE4B0);
    rdw(8'h26, 16'hB000);
    field_raw = 12'h4B1;
    cyc(10);
    rdw(8'h26, 16'hB002);
    chk({15'h0, warning_summary_bit}, 16'h1);
    chk({15'h0, error_indicator}, 16'h0001);
    warn_mask = 16'h0002;
    cyc(1);
    chk({15'h0, warning_summary_bit}, 16'h0);
    warn_summary_mask = 1;
    field_raw = 12'h000;
    cyc(10);
    chk({15'h0, error_indicator}, 16'h0000);
    err_unmasked_any = 1;
    cyc(1);
    chk({15'h0, error_indicator}, 16'h0001);
    err_unmasked_any = 0;
    clr(0);
    rdw(8'h26, 16'hB000);
    $display("test field done");
    stop_test;
  end
endmodule
